//--- logic/i2c_status_flags_low.sv
// Low five event flags of the first status register, with clear sequences.
// Assumes shifter events arrive as one-cycle core_clk pulses; bus pins are async.
`timescale 1ns/1ns
`default_nettype none
module i2c_status_flags_low (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  regAddr,
  input  wire logic [15:0] regWriteData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [15:0] regReadData,
  output logic             irq,
  input  wire logic        masterMode,
  input  wire logic        startSentEvt,
  input  wire logic        stopSentEvt,
  input  wire logic        addrMatchEvt,
  input  wire logic        addrSentEvt,
  input  wire logic        header10SentEvt,
  input  wire logic        ackGivenEvt,
  input  wire logic        rxByteEvt,
  input  wire logic [7:0]  rxByte,
  input  wire logic        txLoadEvt,
  input  wire logic        txShiftDoneEvt,
  input  wire logic        sclPin,
  input  wire logic        sdaPin,
  output logic      [7:0]  txData,
  output logic             peripheralEnable,
  output logic             acknowledgeEnable
);
  localparam int NF = i2c_flags_pkg::NUM_FLAGS;

  typedef struct packed {
    logic [15:0]   rdata;
    logic          irq;
    logic [15:0]   control_first;
    logic          event_irq_enable;
    logic [NF-1:0] flags;
    logic [NF-1:0] armed;
    logic [NF-1:0] sticky;
    logic [NF-1:0] mask;
    logic [7:0]    rxData;
    logic [7:0]    txData;
    logic          rxUnread;
    logic          txHolding;
    logic          ackSeen;
    logic          sclPrev;
    logic          sdaPrev;
  } state_s;

  state_s        q;
  state_s        d;
  logic [1:0]    pinSync;
  logic          sclSync;
  logic          sdaSync;
  logic          enable;
  logic          statusFirstRead;
  logic          statusSecondRead;
  logic          dataRead;
  logic          dataWrite;
  logic          controlFirstWrite;
  logic          stopOnBus;
  logic [NF-1:0] setEvt;
  logic [NF-1:0] accessClr;
  logic [NF-1:0] clrEvt;

  sync_two_flop #(
    .WIDTH (2)
  ) pinSyncInst (
    .core_clk (core_clk),
    .reset    (reset),
    .asyncIn  ({sclPin, sdaPin}),
    .syncOut  (pinSync)
  );

  assign sclSync = pinSync[1];
  assign sdaSync = pinSync[0];
  assign enable  = q.control_first[i2c_flags_pkg::BIT_ENABLE];

  assign statusFirstRead   = regRead && regAddr == i2c_flags_pkg::OFS_STATUS_FIRST;
  assign statusSecondRead  = regRead && regAddr == i2c_flags_pkg::OFS_STATUS_SECOND;
  assign dataRead          = regRead && regAddr == i2c_flags_pkg::OFS_DATA;
  assign dataWrite         = regWrite && regAddr == i2c_flags_pkg::OFS_DATA;
  assign controlFirstWrite = regWrite && regAddr == i2c_flags_pkg::OFS_CONTROL_FIRST;

  // Stop: data rises while clock stays high
  assign stopOnBus = sclSync && q.sclPrev && sdaSync && !q.sdaPrev;

  always_comb begin
    setEvt = '0;
    setEvt[i2c_flags_pkg::BIT_START] = startSentEvt;
    // Mode picks which address event counts
    setEvt[i2c_flags_pkg::BIT_ADDR]  = masterMode ? addrSentEvt : addrMatchEvt;
    setEvt[i2c_flags_pkg::BIT_BYTE]  = (rxByteEvt && q.rxUnread)
                                     || (txShiftDoneEvt && !q.txHolding);
    setEvt[i2c_flags_pkg::BIT_HDR10] = header10SentEvt && masterMode;
    setEvt[i2c_flags_pkg::BIT_STOP]  = stopOnBus && !masterMode && q.ackSeen
                                     && q.control_first[i2c_flags_pkg::BIT_ACK_ENABLE];
  end

  // Only flags armed by an earlier status read can be cleared by an access
  always_comb begin
    accessClr = '0;
    accessClr[i2c_flags_pkg::BIT_START] = dataWrite;
    accessClr[i2c_flags_pkg::BIT_ADDR]  = statusSecondRead;
    accessClr[i2c_flags_pkg::BIT_BYTE]  = dataWrite || dataRead;
    accessClr[i2c_flags_pkg::BIT_HDR10] = dataWrite;
    accessClr[i2c_flags_pkg::BIT_STOP]  = controlFirstWrite;
    accessClr = accessClr & q.armed;
    clrEvt = accessClr;
    clrEvt[i2c_flags_pkg::BIT_BYTE] = accessClr[i2c_flags_pkg::BIT_BYTE]
                                    || startSentEvt || stopSentEvt;
  end

  always_comb begin
    d = q;
    d.sclPrev = sclSync;
    d.sdaPrev = sdaSync;

    // Set wins over clear so a coincident event is never lost
    d.flags = (q.flags & ~clrEvt) | setEvt;
    if (statusFirstRead) begin
      d.armed = q.flags;
    end else begin
      d.armed = q.armed & ~accessClr;
    end

    if (ackGivenEvt) begin
      d.ackSeen = 1'b1;
    end else if (stopOnBus) begin
      d.ackSeen = 1'b0;
    end

    if (rxByteEvt && !q.rxUnread) begin
      d.rxData   = rxByte;
      d.rxUnread = 1'b1;
    end else if (dataRead) begin
      d.rxUnread = 1'b0;
    end

    if (dataWrite) begin
      d.txData    = regWriteData[7:0];
      d.txHolding = 1'b1;
    end else if (txLoadEvt) begin
      d.txHolding = 1'b0;
    end

    if (!enable) begin
      d.flags     = '0;
      d.armed     = '0;
      d.ackSeen   = 1'b0;
      d.rxUnread  = 1'b0;
      d.txHolding = 1'b0;
    end

    // Flags written directly are ignored: a write to the interrupt status register clears only the sticky copies
    if (controlFirstWrite) begin
      d.control_first = regWriteData;
    end
    if (regWrite && regAddr == i2c_flags_pkg::OFS_CONTROL_SECOND) begin
      d.event_irq_enable = regWriteData[i2c_flags_pkg::BIT_EVENT_IRQ];
    end
    if (regWrite && regAddr == i2c_flags_pkg::OFS_IRQ_MASK) begin
      d.mask = regWriteData[NF-1:0];
    end
    d.sticky = q.sticky;
    if (regWrite && regAddr == i2c_flags_pkg::OFS_IRQ_STATUS) begin
      d.sticky = q.sticky & ~regWriteData[NF-1:0];
    end
    d.sticky = d.sticky | q.flags;
    d.irq    = q.event_irq_enable && |(d.sticky & d.mask);

    d.rdata = '0;
    if (regRead) begin
      case (regAddr)
        i2c_flags_pkg::OFS_CONTROL_FIRST:  d.rdata = q.control_first;
        i2c_flags_pkg::OFS_CONTROL_SECOND: d.rdata = 16'(q.event_irq_enable) << i2c_flags_pkg::BIT_EVENT_IRQ;
        i2c_flags_pkg::OFS_DATA:           d.rdata = {8'h00, q.rxData};
        i2c_flags_pkg::OFS_STATUS_FIRST:   d.rdata = {11'h000, q.flags};
        i2c_flags_pkg::OFS_STATUS_SECOND:  d.rdata = 16'(masterMode) << i2c_flags_pkg::BIT_MASTER;
        i2c_flags_pkg::OFS_IRQ_STATUS:     d.rdata = {11'h000, q.sticky};
        i2c_flags_pkg::OFS_IRQ_MASK:       d.rdata = {11'h000, q.mask};
        default:                           d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      q       <= '0;
      q.control_first <= i2c_flags_pkg::CONTROL_RESET;
      q.flags <= i2c_flags_pkg::STATUS_RESET[NF-1:0];
      q.mask  <= i2c_flags_pkg::MASK_RESET;
    end else begin
      q <= d;
    end
  end

  assign regReadData       = q.rdata;
  assign irq               = q.irq;
  assign txData            = q.txData;
  assign peripheralEnable  = q.control_first[i2c_flags_pkg::BIT_ENABLE];
  assign acknowledgeEnable = q.control_first[i2c_flags_pkg::BIT_ACK_ENABLE];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_flag_raised;
    q.event_irq_enable && (q.flags & q.mask) != '0 && !regWrite;
  endsequence

  sequence s_quiet_bus;
    !regWrite;
  endsequence

  a_disable_forces: assert property (!enable |=> q.flags == '0)
    else $error("flags not cleared while disabled");

  a_start_sets: assert property (enable && startSentEvt |=> q.flags[i2c_flags_pkg::BIT_START])
    else $error("start flag not set");

  a_arm_capture: assert property (statusFirstRead && enable |=> q.armed == $past(q.flags))
    else $error("status read not remembered");

  a_addr_release: assert property (
    enable && q.armed[i2c_flags_pkg::BIT_ADDR] && statusSecondRead
    && !setEvt[i2c_flags_pkg::BIT_ADDR] |=> !q.flags[i2c_flags_pkg::BIT_ADDR])
    else $error("address flag not released");

  a_addr_holds: assert property (
    enable && q.flags[i2c_flags_pkg::BIT_ADDR] && !q.armed[i2c_flags_pkg::BIT_ADDR]
    |=> q.flags[i2c_flags_pkg::BIT_ADDR])
    else $error("address flag cleared without read pair");

  a_rx_overrun: assert property (enable && rxByteEvt && q.rxUnread
    |=> q.flags[i2c_flags_pkg::BIT_BYTE])
    else $error("byte flag not set on overrun");

  a_byte_hwclear: assert property (
    enable && (startSentEvt || stopSentEvt) && !setEvt[i2c_flags_pkg::BIT_BYTE]
    |=> !q.flags[i2c_flags_pkg::BIT_BYTE])
    else $error("byte flag survives start or stop");

  a_hdr_clear: assert property (
    enable && q.armed[i2c_flags_pkg::BIT_HDR10] && dataWrite
    && !setEvt[i2c_flags_pkg::BIT_HDR10] |=> !q.flags[i2c_flags_pkg::BIT_HDR10])
    else $error("header flag not cleared");

  a_stop_sets: assert property (
    enable && !masterMode && acknowledgeEnable && q.ackSeen && stopOnBus
    |=> q.flags[i2c_flags_pkg::BIT_STOP])
    else $error("stop flag not set");

  a_irq_raise: assert property (s_flag_raised ##1 s_quiet_bus |=> irq)
    else $error("interrupt not raised for set flag");

  a_status_read: assert property (statusFirstRead
    |=> regReadData == {11'h000, $past(q.flags)})
    else $error("status read data wrong");
endmodule : i2c_status_flags_low
`default_nettype wire

//--- include/i2c_flags_pkg.sv
// Constants for the low status flags of the two-wire bus controller.
// Assumes a 16-bit register port with byte offsets on an 8-bit address.
package i2c_flags_pkg;
  localparam int          NUM_FLAGS          = 5;
  localparam logic [7:0]  OFS_CONTROL_FIRST  = 8'h00;
  localparam logic [7:0]  OFS_CONTROL_SECOND = 8'h04;
  localparam logic [7:0]  OFS_DATA           = 8'h10;
  localparam logic [7:0]  OFS_STATUS_FIRST   = 8'h14;
  localparam logic [7:0]  OFS_STATUS_SECOND  = 8'h18;
  localparam logic [7:0]  OFS_IRQ_STATUS     = 8'h20;
  localparam logic [7:0]  OFS_IRQ_MASK       = 8'h24;
  localparam int          BIT_START          = 0;
  localparam int          BIT_ADDR           = 1;
  localparam int          BIT_BYTE           = 2;
  localparam int          BIT_HDR10          = 3;
  localparam int          BIT_STOP           = 4;
  localparam int          BIT_ENABLE         = 0;
  localparam int          BIT_ACK_ENABLE     = 10;
  localparam int          BIT_EVENT_IRQ      = 9;
  localparam int          BIT_MASTER         = 0;
  localparam logic [15:0] STATUS_RESET       = 16'h0000;
  localparam logic [15:0] CONTROL_RESET      = 16'h0000;
  localparam logic [4:0]  MASK_RESET         = 5'h00;
endpackage : i2c_flags_pkg

//--- logic/sync_two_flop.sv
// Two-flop synchroniser for levels arriving from outside core_clk.
// Assumes inputs change slowly relative to core_clk.
`timescale 1ns/1ns
`default_nettype none
module sync_two_flop #(
  parameter int WIDTH = 2
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_s;

  sync_s q;
  sync_s d;

  always_comb begin
    d.meta   = asyncIn;
    d.stable = q.meta;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign syncOut = q.stable;
endmodule : sync_two_flop
`default_nettype wire

//--- tb/i2c_bus_far_end.sv
// Far-side bus device: open-drain lines that idle at the pull-up level.
// Assumes go is a level from the bench; each rise sends start, one clock, stop.
`timescale 1ns/1ns
`default_nettype none
module i2c_bus_far_end (
  input  wire logic go,
  output logic      sclPin,
  output logic      sdaPin
);
  initial begin
    sclPin = 1'b1;
    sdaPin = 1'b1;
  end
  // Clock runs at 160 ns only inside the frame, still outside it
  // Offset keeps pin changes off the core_clk sampling edges
  always @(posedge go) begin
    #3 sdaPin = 1'b0;
    #80 sclPin = 1'b0;
    #80 sclPin = 1'b1;
    #80 sdaPin = 1'b1;
  end
endmodule : i2c_bus_far_end
`default_nettype wire

//--- tb/i2c_status_flags_low_tb.sv
// Self-checking bench for the low status flags and their clear sequences.
// Assumes the package constants and the far-side model in tb/.
`timescale 1ns/1ns
`default_nettype none
module i2c_status_flags_low_tb;
  typedef struct packed {
    logic [3:0]  ev;
    logic        mm;
    logic [15:0] flag;
    logic [7:0]  cAddr;
    logic        cWr;
  } row_s;
  logic        core_clk, reset, regWrite, regRead, masterMode, go;
  logic        irq, peripheralEnable, acknowledgeEnable, sclPin, sdaPin;
  logic [7:0]  regAddr, rxByte, txData;
  logic [15:0] regWriteData, regReadData, d;
  logic [8:0]  ev;
  int          failures, n_compared, i;
  row_s        rows [4];

  i2c_status_flags_low DUT (.core_clk(core_clk), .reset(reset), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .irq(irq), .masterMode(masterMode),
    .startSentEvt(ev[0]), .stopSentEvt(ev[1]), .addrMatchEvt(ev[2]),
    .addrSentEvt(ev[3]), .header10SentEvt(ev[4]), .ackGivenEvt(ev[5]),
    .rxByteEvt(ev[6]), .rxByte(rxByte), .txLoadEvt(ev[7]), .txShiftDoneEvt(ev[8]),
    .sclPin(sclPin), .sdaPin(sdaPin), .txData(txData),
    .peripheralEnable(peripheralEnable), .acknowledgeEnable(acknowledgeEnable));
  i2c_bus_far_end far (.go(go), .sclPin(sclPin), .sdaPin(sdaPin));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge core_clk);
    regAddr      <= a;
    regWriteData <= v;
    regWrite     <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask : wr
  // Data sampled just after the edge that ends the read
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 d = regReadData;
  endtask : rd
  task automatic pulse(input int k);
    @(posedge core_clk);
    ev <= 9'h001 << k;
    @(posedge core_clk);
    ev <= 9'h000;
  endtask : pulse
  task automatic clr(input logic [7:0] a, input logic w);
    if (w) wr(a, 16'h0033);
    else rd(a);
  endtask : clr
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    reset = 1'b1;
    {regWrite, regRead, masterMode, go, regAddr, rxByte, regWriteData, ev, d} = '0;
    failures = 0;
    n_compared = 0;
    rows = '{'{4'h0, 1'b1, 16'h0001, i2c_flags_pkg::OFS_DATA, 1'b1},
             '{4'h2, 1'b0, 16'h0002, i2c_flags_pkg::OFS_STATUS_SECOND, 1'b0},
             '{4'h3, 1'b1, 16'h0002, i2c_flags_pkg::OFS_STATUS_SECOND, 1'b0},
             '{4'h4, 1'b1, 16'h0008, i2c_flags_pkg::OFS_DATA, 1'b1}};
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    rd(i2c_flags_pkg::OFS_STATUS_FIRST);
    chk(d, i2c_flags_pkg::STATUS_RESET);
    wr(i2c_flags_pkg::OFS_CONTROL_FIRST, 16'h0401);
    wr(i2c_flags_pkg::OFS_CONTROL_SECOND, 16'h0200);
    wr(i2c_flags_pkg::OFS_IRQ_MASK, 16'h001f);
    // Clear access before the status read must leave the flag alone
    for (i = 0; i < 4; i++) begin
      masterMode <= rows[i].mm;
      pulse(rows[i].ev);
      clr(rows[i].cAddr, rows[i].cWr);
      rd(i2c_flags_pkg::OFS_STATUS_FIRST);
      chk(d, rows[i].flag);
      chk({15'h0000, irq}, 16'h0001);
      clr(rows[i].cAddr, rows[i].cWr);
      rd(i2c_flags_pkg::OFS_STATUS_FIRST);
      chk(d, 16'h0000);
      wr(i2c_flags_pkg::OFS_IRQ_STATUS, 16'h001f);
      rd(i2c_flags_pkg::OFS_IRQ_STATUS);
      chk(d, 16'h0000);
      chk({15'h0000, irq}, 16'h0000);
    end
    rxByte <= 8'h5a;
    pulse(6);
    rxByte <= 8'ha5;
    pulse(6);
    rd(i2c_flags_pkg::OFS_STATUS_FIRST);
    chk(d, 16'h0004);
    chk({14'h0000, acknowledgeEnable, peripheralEnable}, 16'h0003);
    rd(i2c_flags_pkg::OFS_DATA);
    chk(d, 16'h005a);
    rd(i2c_flags_pkg::OFS_STATUS_FIRST);
    chk(d, 16'h0000);
    wr(i2c_flags_pkg::OFS_DATA, 16'h00c3);
    pulse(7);
    chk({8'h00, txData}, 16'h00c3);
    pulse(8);
    rd(i2c_flags_pkg::OFS_STATUS_FIRST);
    chk(d, 16'h0004);
    wr(i2c_flags_pkg::OFS_STATUS_FIRST, 16'h0000);
    rd(i2c_flags_pkg::OFS_STATUS_FIRST);
    chk(d, 16'h0004);
    pulse(0);
    rd(i2c_flags_pkg::OFS_STATUS_FIRST);
    chk(d, 16'h0001);
    // Byte flag set by an empty transmit, then dropped by our own stop
    pulse(8);
    pulse(1);
    rd(i2c_flags_pkg::OFS_STATUS_FIRST);
    chk(d, 16'h0001);
    wr(i2c_flags_pkg::OFS_IRQ_MASK, 16'h0000);
    wr(i2c_flags_pkg::OFS_IRQ_STATUS, 16'h001f);
    rd(i2c_flags_pkg::OFS_STATUS_FIRST);
    chk({15'h0000, irq}, 16'h0000);
    wr(i2c_flags_pkg::OFS_CONTROL_FIRST, 16'h0000);
    rd(i2c_flags_pkg::OFS_STATUS_FIRST);
    chk(d, 16'h0000);
    chk({14'h0000, acknowledgeEnable, peripheralEnable}, 16'h0000);
    wr(i2c_flags_pkg::OFS_CONTROL_FIRST, 16'h0401);
    masterMode <= 1'b0;
    pulse(5);
    go <= 1'b1;
    for (i = 0; i < 100 && d[4] !== 1'b1; i++) rd(i2c_flags_pkg::OFS_STATUS_FIRST);
    chk(d, 16'h0010);
    // A stop never seen counts as a mismatch of its own
    if (i == 100) failures++;
    wr(i2c_flags_pkg::OFS_CONTROL_FIRST, 16'h0401);
    rd(i2c_flags_pkg::OFS_STATUS_FIRST);
    chk(d, 16'h0000);
    // Reset in mid-run with a flag set and the block enabled
    pulse(0);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    #1 chk({13'h0000, irq, peripheralEnable, acknowledgeEnable}, 16'h0000);
    chk(regReadData, 16'h0000);
    rd(i2c_flags_pkg::OFS_STATUS_FIRST);
    chk(d, i2c_flags_pkg::STATUS_RESET);
    summarize();
  end
endmodule : i2c_status_flags_low_tb
`default_nettype wire
